// [design/lsr_regs.sv]
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
// Contract
// - stop_in_wait set stops the driver while the CPU waits.
// - run_in_pseudo_stop clear stops the driver in pseudo stop.
// - Each frontplane enable gates its pin while driver enabled.
// - Frontplane enable 0 disables the pin, 1 enables it.
// - With driver disabled, frontplane enables do not affect pins.
// - Segment memory is 16 bytes, readable and writable anytime.
// - Segment memory is not reset; contents undefined after reset.
// - Byte k: frontplane 2k in bits 3:0, 2k+1 in 7:4.
// - Segment bit 1 means segment on, 0 means off.
// - Driver disabled: all outputs off, waveform clocks stopped.
// - Reset clears frontplane enables and driver enable.
module lsr_regs
    import lsr_pkg::*;
#(
    parameter int NUM_FP = LSR_NUM_FP,
    parameter int NUM_BP = LSR_NUM_BP,
    parameter int SEG_BYTES = LSR_SEG_BYTES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire lsr_bus_req_t bus_req,
    output logic [LSR_DATA_W-1:0] bus_rdata,
    // CPU power mode indications
    input wire lsr_power_mode_t power_mode,
    // Waveform generator side
    output lsr_drive_t drive,
    output logic [LSR_SEG_BITS-1:0] segment_on_bit
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NUM_FP != LSR_NUM_FP) begin : g_bad_fp
        $error("lsr_regs: only 32 frontplanes are supported");
    end
    if (NUM_BP != LSR_NUM_BP) begin : g_bad_bp
        $error("lsr_regs: only 4 backplanes are supported");
    end
    if (SEG_BYTES * LSR_DATA_W != NUM_FP * NUM_BP) begin : g_bad_seg
        $error("lsr_regs: segment memory must hold one bit a segment");
    end

    localparam int FPEN_REGS = NUM_FP / LSR_DATA_W;
    localparam int IDX_W = 4;
    localparam int FPEN_SPAN = int'(LSR_OFF_FPEN_3 - LSR_OFF_FPEN_0) + 1;
    localparam int SEG_SPAN = int'(LSR_OFF_SEG_15 - LSR_OFF_SEG_0) + 1;
    // Two frontplanes share a segment byte, one nibble each
    localparam int FP_PER_BYTE = LSR_DATA_W / LSR_NIBBLE_W;

    if (NUM_FP % LSR_DATA_W != 0) begin : g_bad_fp_bytes
        $error("lsr_regs: frontplanes must fill whole enable bytes");
    end
    if (FPEN_SPAN != FPEN_REGS) begin : g_bad_fpen_map
        $error("lsr_regs: enable window and frontplane count differ");
    end
    if (SEG_SPAN != SEG_BYTES) begin : g_bad_seg_map
        $error("lsr_regs: segment window and memory size differ");
    end
    if (SEG_BYTES > (1 << IDX_W)) begin : g_bad_idx
        $error("lsr_regs: group index too narrow for the memory");
    end
    if (NUM_BP != LSR_NIBBLE_W) begin : g_bad_nibble
        $error("lsr_regs: one nibble must hold all backplanes");
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic lsr_sel_t decode(input logic [LSR_ADDR_W-1:0] a);
        lsr_sel_t s;
        s = LSR_SEL_NONE;
        if (a == LSR_OFF_DRV_CTRL) begin
            s = LSR_SEL_DRV_CTRL;
        end else if (a == LSR_OFF_LOW_POWER) begin
            s = LSR_SEL_LOW_POWER;
        end else if (a >= LSR_OFF_FPEN_0 && a <= LSR_OFF_FPEN_3) begin
            s = LSR_SEL_FPEN;
        end else if (a >= LSR_OFF_SEG_0 && a <= LSR_OFF_SEG_15) begin
            s = LSR_SEL_SEG;
        end
        return s;
    endfunction

    // Index of a byte within a register group
    function automatic logic [3:0] group_index(
        input logic [LSR_ADDR_W-1:0] a,
        input logic [LSR_ADDR_W-1:0] base
    );
        logic [LSR_ADDR_W-1:0] diff;
        diff = a - base;
        return diff[3:0];
    endfunction

    lsr_sel_t wr_sel;
    lsr_sel_t rd_sel;
    logic [3:0] wr_idx_fpen;
    logic [3:0] wr_idx_seg;
    logic [3:0] rd_idx_fpen;
    logic [3:0] rd_idx_seg;

    always_comb begin
        wr_sel = decode(bus_req.addr);
        rd_sel = decode(bus_req.addr);
        wr_idx_fpen = group_index(bus_req.addr, LSR_OFF_FPEN_0);
        wr_idx_seg = group_index(bus_req.addr, LSR_OFF_SEG_0);
        rd_idx_fpen = wr_idx_fpen;
        rd_idx_seg = wr_idx_seg;
    end

    // Write strobes, one for each register group
    logic wr_drv_ctrl;
    logic wr_low_power;
    logic wr_fpen;
    logic wr_seg;

    always_comb begin
        wr_drv_ctrl = bus_req.wr && (wr_sel == LSR_SEL_DRV_CTRL);
        wr_low_power = bus_req.wr && (wr_sel == LSR_SEL_LOW_POWER);
        wr_fpen = bus_req.wr && (wr_sel == LSR_SEL_FPEN);
        wr_seg = bus_req.wr && (wr_sel == LSR_SEL_SEG);
    end

    // ------------------------------------------------------------
    // Driver system enable
    // ------------------------------------------------------------
    logic drv_en_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            drv_en_q <= LSR_RST_DRV_EN;
        end else if (wr_drv_ctrl) begin
            drv_en_q <= bus_req.wdata[LSR_BIT_DRV_EN];
        end
    end

    // ------------------------------------------------------------
    // Low-power control
    // ------------------------------------------------------------
    logic stop_in_wait_q;
    logic run_in_pseudo_stop_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stop_in_wait_q <= LSR_RST_STOP_IN_WAIT;
            run_in_pseudo_stop_q <= LSR_RST_RUN_IN_PSTOP;
        end else if (wr_low_power) begin
            stop_in_wait_q <= bus_req.wdata[LSR_BIT_STOP_IN_WAIT];
            run_in_pseudo_stop_q <= bus_req.wdata[LSR_BIT_RUN_IN_PSTOP];
        end
    end

    // ------------------------------------------------------------
    // Frontplane enables
    // ------------------------------------------------------------
    logic [NUM_FP-1:0] fpen_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fpen_q <= LSR_RST_FPEN[NUM_FP-1:0];
        end else if (wr_fpen) begin
            for (int i = 0; i < FPEN_REGS; i++) begin
                if (wr_idx_fpen == 4'(i)) begin
                    fpen_q[i*LSR_DATA_W +: LSR_DATA_W] <= bus_req.wdata;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Segment memory
    // ------------------------------------------------------------
    // No reset on purpose: the array stays plain storage, and software
    // has to load every byte before it turns the display on.
    logic [LSR_DATA_W-1:0] seg_mem [SEG_BYTES];

    always_ff @(posedge core_clk) begin
        if (wr_seg) begin
            seg_mem[wr_idx_seg] <= bus_req.wdata;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    function automatic logic [LSR_DATA_W-1:0] read_value(
        input lsr_sel_t s,
        input logic [3:0] fi,
        input logic [3:0] si
    );
        logic [LSR_DATA_W-1:0] v;
        v = LSR_RD_ZERO;
        case (s)
            LSR_SEL_DRV_CTRL: begin
                v[LSR_BIT_DRV_EN] = drv_en_q;
            end
            LSR_SEL_LOW_POWER: begin
                v[LSR_BIT_STOP_IN_WAIT] = stop_in_wait_q;
                v[LSR_BIT_RUN_IN_PSTOP] = run_in_pseudo_stop_q;
            end
            LSR_SEL_FPEN: begin
                for (int i = 0; i < FPEN_REGS; i++) begin
                    if (fi == 4'(i)) begin
                        v = fpen_q[i*LSR_DATA_W +: LSR_DATA_W];
                    end
                end
            end
            LSR_SEL_SEG: begin
                v = seg_mem[si];
            end
            default: begin
                v = LSR_RD_ZERO;
            end
        endcase
        return v;
    endfunction

    logic [LSR_DATA_W-1:0] rdata_q;

    // byte read
    // Data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= LSR_RD_ZERO;
        end else if (bus_req.rd) begin
            rdata_q <= read_value(rd_sel, rd_idx_fpen, rd_idx_seg);
        end else begin
            rdata_q <= LSR_RD_ZERO;
        end
    end

    assign bus_rdata = rdata_q;

    // ------------------------------------------------------------
    // Power-mode gating
    // ------------------------------------------------------------
    logic wait_stop;
    logic pstop_stop;
    logic driver_run;

    // Mode indications come from core logic on this clock,
    // so they are used without a synchroniser.
    always_comb begin
        wait_stop = power_mode.cpu_wait && stop_in_wait_q;
        pstop_stop = power_mode.cpu_pseudo_stop && !run_in_pseudo_stop_q;
        driver_run = drv_en_q && !wait_stop && !pstop_stop;
    end

    // ------------------------------------------------------------
    // Pin drive enables
    // ------------------------------------------------------------
    // The enables follow the driver enable flop, not the power-mode
    // gating: a stopped waveform generator freezes but the pads keep
    // their configuration, so wake-up needs no reprogramming.
    always_comb begin
        drive.driver_run = driver_run;
        drive.backplane_drive = {NUM_BP{drv_en_q}};
        drive.frontplane_drive = fpen_q & {NUM_FP{drv_en_q}};
    end

    // ------------------------------------------------------------
    // Segment bits to the waveform generator
    // ------------------------------------------------------------
    // Segment (fp, bp) sits at bit fp*NUM_BP+bp, so the generator
    // indexes the vector directly with no knowledge of the byte map.
    function automatic int seg_flat_bit(input int fp, input int bp);
        return fp * NUM_BP + bp;
    endfunction

    function automatic int seg_byte_of(input int fp);
        return fp / FP_PER_BYTE;
    endfunction

    function automatic int seg_bit_of(input int fp, input int bp);
        return (fp % FP_PER_BYTE) * LSR_NIBBLE_W + bp;
    endfunction

    always_comb begin
        for (int fp = 0; fp < NUM_FP; fp++) begin
            for (int bp = 0; bp < NUM_BP; bp++) begin
                segment_on_bit[seg_flat_bit(fp, bp)] =
                    seg_mem[seg_byte_of(fp)][seg_bit_of(fp, bp)];
            end
        end
    end

endmodule // lsr_regs

// [inc/lsr_pkg.sv]
package lsr_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int LSR_NUM_FP = 32;
    localparam int LSR_NUM_BP = 4;
    localparam int LSR_SEG_BYTES = 16;
    localparam int LSR_SEG_BITS = LSR_NUM_FP * LSR_NUM_BP;
    localparam int LSR_ADDR_W = 5;
    localparam int LSR_DATA_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] LSR_OFF_DRV_CTRL = 5'h00;
    localparam logic [4:0] LSR_OFF_LOW_POWER = 5'h01;
    localparam logic [4:0] LSR_OFF_FPEN_0 = 5'h02;
    localparam logic [4:0] LSR_OFF_FPEN_3 = 5'h05;
    localparam logic [4:0] LSR_OFF_SEG_0 = 5'h08;
    localparam logic [4:0] LSR_OFF_SEG_15 = 5'h17;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LSR_BIT_DRV_EN = 7;
    localparam int LSR_BIT_STOP_IN_WAIT = 1;
    localparam int LSR_BIT_RUN_IN_PSTOP = 0;
    localparam int LSR_NIBBLE_W = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic LSR_RST_DRV_EN = 1'h0;
    localparam logic LSR_RST_STOP_IN_WAIT = 1'h0;
    localparam logic LSR_RST_RUN_IN_PSTOP = 1'h0;
    localparam logic [31:0] LSR_RST_FPEN = 32'h0000_0000;
    localparam logic [7:0] LSR_RD_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [LSR_ADDR_W-1:0] addr;
        logic [LSR_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } lsr_bus_req_t;

    typedef struct packed {
        logic cpu_wait;
        logic cpu_pseudo_stop;
    } lsr_power_mode_t;

    typedef struct packed {
        logic driver_run;
        logic [LSR_NUM_BP-1:0] backplane_drive;
        logic [LSR_NUM_FP-1:0] frontplane_drive;
    } lsr_drive_t;

    typedef enum logic [2:0] {
        LSR_SEL_NONE,
        LSR_SEL_DRV_CTRL,
        LSR_SEL_LOW_POWER,
        LSR_SEL_FPEN,
        LSR_SEL_SEG
    } lsr_sel_t;

endpackage

// [sim/lsr_regs_bench.sv]
`timescale 1ns/1ns
module lsr_regs_bench
    import lsr_pkg::*;
;
    logic core_clk;
    logic rst;
    lsr_bus_req_t bus_req;
    logic [7:0] bus_rdata;
    lsr_power_mode_t power_mode;
    lsr_drive_t drive;
    logic [127:0] segment_on_bit;
    logic [127:0] seg_shown;
    logic [127:0] exp_seg;
    logic [127:0] shown;
    logic [31:0] fpv = 32'h7e813ca5;
    logic [4:0] unm [4] = '{5'h06, 5'h07, 5'h18, 5'h1f};
    logic [7:0] rd;
    logic run_exp;
    int n_errors = 0;
    int check_count = 0;
    lsr_regs dut (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .power_mode(power_mode), .drive(drive),
        .segment_on_bit(segment_on_bit));
    lsr_wave_model u_wave (.drive(drive), .segment_on_bit(segment_on_bit),
        .seg_shown(seg_shown));
    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;
    // ------------------------------
    // Bus tasks
    // ------------------------------
    task automatic check(input string what, input logic [127:0] seen,
                         input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        @(negedge core_clk);
        rd = bus_rdata;
        check("register read", 128'(rd), 128'(e));
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Far above the 170 or so cycles the sequence needs
    initial begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        complete_run();
    end
    // ------------------------------
    // Sequence
    // ------------------------------
    initial begin
        rst = 1'b1;
        bus_req = '0;
        power_mode = '0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check("drive at reset", 128'(drive), 128'(0));
        for (int a = 0; a < 6; a++) rd_chk(5'(a), 8'h00);
        foreach (unm[i]) begin
            wr_reg(unm[i], 8'hff);
            rd_chk(unm[i], 8'h00);
        end
        for (int k = 0; k < 16; k++) begin
            exp_seg[k*8 +: 8] = {4'(k), ~4'(k)};
            wr_reg(5'(8 + k), {4'(k), ~4'(k)});
        end
        wr_reg(5'h0d, 8'h20);
        exp_seg[47:40] = 8'h20;
        @(negedge core_clk);
        check("fp11 bp1", 128'(segment_on_bit[45]), 128'(1));
        check("segments", segment_on_bit, exp_seg);
        for (int k = 0; k < 16; k++) begin
            rd_chk(5'(8 + k), exp_seg[k*8 +: 8]);
        end
        // enables loaded before the driver is switched on
        for (int n = 0; n < 4; n++) wr_reg(5'(2 + n), fpv[n*8 +: 8]);
        @(negedge core_clk);
        check("fp while off", 128'(drive), 128'(0));
        for (int n = 0; n < 4; n++) begin
            rd_chk(5'(2 + n), fpv[n*8 +: 8]);
        end
        wr_reg(5'h00, 8'h80);
        @(negedge core_clk);
        check("fp drive", 128'(drive.frontplane_drive), 128'(fpv));
        check("bp drive", 128'(drive.backplane_drive), 128'(4'hf));
        for (int i = 0; i < 128; i++) shown[i] = fpv[i/4] && exp_seg[i];
        check("lit segments", seg_shown, shown);
        rd_chk(5'h00, 8'h80);
        wr_reg(5'h02, 8'h00);
        @(negedge core_clk);
        check("fp0 off", 128'(drive.frontplane_drive[7:0]), '0);
        for (int lp = 0; lp < 4; lp++) begin
            wr_reg(5'h01, 8'(lp));
            rd_chk(5'h01, 8'(lp));
            for (int m = 0; m < 4; m++) begin
                @(posedge core_clk);
                power_mode <= 2'(m);
                run_exp = !(m[1] && lp[1]) && !(m[0] && !lp[0]);
                @(negedge core_clk);
                check("run", 128'(drive.driver_run),
                    128'(run_exp));
            end
            @(posedge core_clk);
            power_mode <= '0;
        end
        wr_reg(5'h00, 8'h00);
        @(negedge core_clk);
        check("drive off", 128'(drive), 128'(0));
        check("segments kept", segment_on_bit, exp_seg);
        wr_reg(5'h00, 8'h80);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check("drive re-reset", 128'(drive), 128'(0));
        rd_chk(5'h03, 8'h00);
        complete_run();
    end
endmodule // lsr_regs_bench

// [sim/lsr_regs_properties.sv]
`timescale 1ns/1ns
module lsr_regs_properties
    import lsr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Ports watched
    input wire lsr_bus_req_t bus_req,
    input wire logic [LSR_DATA_W-1:0] bus_rdata,
    input wire lsr_power_mode_t power_mode,
    input wire lsr_drive_t drive,
    input wire logic [LSR_SEG_BITS-1:0] segment_on_bit
);
    // Shadow of control bits, rebuilt from bus writes
    logic en_q;
    logic [1:0] lp_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            en_q <= 1'b0;
            lp_q <= 2'h0;
        end else if (bus_req.wr && bus_req.addr == 5'h00) begin
            en_q <= bus_req.wdata[7];
        end else if (bus_req.wr && bus_req.addr == 5'h01) begin
            lp_q <= bus_req.wdata[1:0];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_rd_idle: assert property (!$past(bus_req.rd) |->
        bus_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    chk_seg_write: assert property (bus_req.wr &&
        bus_req.addr inside {[5'h08:5'h17]} |=> 8'(segment_on_bit >>
        (8 * (int'($past(bus_req.addr)) - 8))) == $past(bus_req.wdata))
        else $error("segment byte not written");
    chk_seg_read: assert property (bus_req.rd &&
        bus_req.addr inside {[5'h08:5'h17]} |=> bus_rdata == 8'($past(
        segment_on_bit) >> (8 * (int'($past(bus_req.addr)) - 8))))
        else $error("segment read data wrong");
    chk_fp_write: assert property (bus_req.wr && en_q &&
        bus_req.addr inside {[5'h02:5'h05]} |=> 8'(drive.frontplane_drive >>
        (8 * (int'($past(bus_req.addr)) - 2))) == $past(bus_req.wdata))
        else $error("frontplane enable not applied");
    chk_fp_off: assert property (!en_q |->
        drive.frontplane_drive == '0)
        else $error("frontplane driven while disabled");
    chk_run_bp: assert property (drive.driver_run |->
        drive.backplane_drive == 4'hf) else $error("run without backplanes");
    chk_wait_stop: assert property (power_mode.cpu_wait && lp_q[1]
        |-> !drive.driver_run) else $error("driver runs in wait");
    chk_pstop_stop: assert property (power_mode.cpu_pseudo_stop &&
        !lp_q[0] |-> !drive.driver_run) else $error("driver runs in pstop");
    chk_run_on: assert property (en_q && !power_mode.cpu_wait &&
        !power_mode.cpu_pseudo_stop |-> drive.driver_run)
        else $error("driver not running when enabled");
    chk_reset_clear: assert property ($past(rst) |-> drive == '0)
        else $error("outputs not cleared by reset");
endmodule // lsr_regs_properties

bind lsr_regs lsr_regs_properties u_chk (.core_clk(core_clk), .rst(rst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .power_mode(power_mode),
    .drive(drive), .segment_on_bit(segment_on_bit));

// [sim/lsr_wave_model.sv]
`timescale 1ns/1ns
module lsr_wave_model
    import lsr_pkg::*;
(
    // Drive state
    input wire lsr_drive_t drive,
    input wire logic [LSR_SEG_BITS-1:0] segment_on_bit,
    // Segments shown lit
    output logic [LSR_SEG_BITS-1:0] seg_shown
);
    always_comb begin
        for (int i = 0; i < LSR_SEG_BITS; i++) begin
            seg_shown[i] = drive.driver_run && drive.frontplane_drive[i/4]
                && segment_on_bit[i];
        end
    end
endmodule // lsr_wave_model
